// ===== rtl/tbp_pkg.sv
// Constants and state types for the buffered compare / PWM timer block
package tbp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TBP_TCS_ADDR = 8'h00;
  localparam logic [7:0] TBP_PERIOD_ADDR = 8'h04;
  localparam logic [7:0] TBP_C0CS_ADDR = 8'h08;
  localparam logic [7:0] TBP_C0CMP_ADDR = 8'h0c;
  localparam logic [7:0] TBP_C1CS_ADDR = 8'h10;
  localparam logic [7:0] TBP_C1CMP_ADDR = 8'h14;
  localparam logic [7:0] TBP_COUNT_ADDR = 8'h18;
  localparam logic [7:0] TBP_ACTIVE_ADDR = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TBP_TCS_OVF = 7;
  localparam int TBP_TCS_OIE = 6;
  localparam int TBP_TCS_HALT = 5;
  localparam int TBP_TCS_CRST = 4;
  localparam int TBP_CS_FLAG = 7;
  localparam int TBP_CS_IE = 6;
  localparam int TBP_CS_LINK = 5;
  localparam int TBP_CS_MODE = 4;
  localparam int TBP_CS_ELH = 3;
  localparam int TBP_CS_ELL = 2;
  localparam int TBP_CS_TOV = 1;
  localparam int TBP_CS_MAX = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] TBP_PERIOD_RST = 16'hffff;
  localparam logic [15:0] TBP_CMP_RST = 16'h0000;
  localparam logic [1:0] TBP_EDGE_TOGGLE = 2'h1;
  localparam logic [1:0] TBP_EDGE_CLEAR = 2'h2;
  localparam logic [1:0] TBP_EDGE_SET = 2'h3;
  localparam logic [1:0] TBP_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic flag;
    logic ie;
    logic link;
    logic mode_select_low;
    logic edge_level_high;
    logic edge_level_low;
    logic toggle_on_overflow;
    logic max_duty_select;
    logic [15:0] cmp;
  } tbp_chan_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] period;
    logic overflow_flag;
    logic ovf_ie;
    logic counter_halt;
    tbp_chan_type [1:0] ch;
    logic active;
    logic last_wr;
    logic [1:0] pin;
    logic [1:0] oe;
    logic ovf_irq;
    logic [1:0] ch_irq;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tbp_state_type;

endpackage : tbp_pkg

// ===== rtl/tbp_timer.sv
// Two-channel 16-bit compare / PWM timer with buffered channel linking
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - Link bit set pairs channels 0 and 1, output only on chan0_pin.
// - Channel 0 value governs first; channel 1 write takes over at overflow.
// - At each later overflow the most recently written pair becomes active.
// - Linked: chan0 control configures and reports; chan1 control ignored.
// - Linked: chan1 pin released from timer control for general I/O.
// - Writes to the active pair take effect at once, unbuffered.
// - Toggle-on-overflow inverts the pin whenever counter reaches period.
// - On compare, edge/level 1:0 drives low, 1:1 drives high.
// - Mode field 0:1 selects unbuffered, 1:0 selects buffered linked.
// - Link bit takes priority over the other channel-0 mode bit.
// - Toggle-on-overflow clear means no overflow toggle: with clear on compare, steady 0% duty.
// - Max-duty and toggle-on-overflow both set give constant 100% duty.
// - PWM period is period value plus one counter clocks.
// - Pulse width equals compare value in clocks after overflow.
// - Channel interrupt at pulse end, overflow interrupt at period end.
// - Overflow and channel flags set on events; enabled flags request irq.
// - Counter reset clears count; halt freezes it; reset sets halt.
module tbp_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic chan0_pin_o,
  output logic chan0_pin_oe_o,
  output logic chan1_pin_o,
  output logic chan1_pin_oe_o,
  output logic ovf_irq_o,
  output logic chan0_irq_o,
  output logic chan1_irq_o
);

  tbp_pkg::tbp_state_type s_q;
  tbp_pkg::tbp_state_type s_d;

  logic run;
  logic wrap;
  logic linked;
  logic [1:0] en;
  logic [1:0] match;
  logic [15:0] cmp_val [2];
  logic [7:0] wr_byte;
  logic [15:0] wr_half;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_val;
  logic p;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    run = !s_q.counter_halt;
    wrap = run && (s_q.cnt == s_q.period);
    linked = s_q.ch[0].link;
    // Link bit outranks the mode low bit, so 1:1 still means buffered
    en[0] = s_q.ch[0].link | s_q.ch[0].mode_select_low;
    en[1] = !linked && s_q.ch[1].mode_select_low;
    // Active pair read straight from the registers: no shadow copy
    cmp_val[0] = (linked && s_q.active) ? s_q.ch[1].cmp
                                        : s_q.ch[0].cmp;
    cmp_val[1] = s_q.ch[1].cmp;
    wr_byte = s_q.wdata[7:0];
    wr_half = s_q.ch[0].cmp;
    wr_ok = 1'b0;
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    p = 1'b0;

    // ------------------------------------------------------------
    // Bus write channel
    // ------------------------------------------------------------
    if (s_axi_awvalid_i && s_q.awready) begin
      s_d.awready = 1'b0;
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_q.wready) begin
      s_d.wready = 1'b0;
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      wr_ok = 1'b1;
      case (s_q.awaddr)
        tbp_pkg::TBP_TCS_ADDR: begin
          if (s_q.wstrb[0]) begin
            // Flag clears by writing 0; writing 1 does nothing
            if (!wr_byte[tbp_pkg::TBP_TCS_OVF]) begin
              s_d.overflow_flag = 1'b0;
            end
            s_d.ovf_ie = wr_byte[tbp_pkg::TBP_TCS_OIE];
            s_d.counter_halt = wr_byte[tbp_pkg::TBP_TCS_HALT];
          end
        end
        tbp_pkg::TBP_PERIOD_ADDR: begin
          if (s_q.wstrb[0]) s_d.period[7:0] = s_q.wdata[7:0];
          if (s_q.wstrb[1]) s_d.period[15:8] = s_q.wdata[15:8];
        end
        tbp_pkg::TBP_C0CS_ADDR, tbp_pkg::TBP_C1CS_ADDR: begin
          for (int x = 0; x < 2; x++) begin
            if (s_q.wstrb[0] && s_q.awaddr == (x == 0 ?
                tbp_pkg::TBP_C0CS_ADDR : tbp_pkg::TBP_C1CS_ADDR)) begin
              if (!wr_byte[tbp_pkg::TBP_CS_FLAG]) s_d.ch[x].flag = 1'b0;
              s_d.ch[x].ie = wr_byte[tbp_pkg::TBP_CS_IE];
              s_d.ch[x].link = (x == 0) && wr_byte[tbp_pkg::TBP_CS_LINK];
              s_d.ch[x].mode_select_low = wr_byte[tbp_pkg::TBP_CS_MODE];
              s_d.ch[x].edge_level_high = wr_byte[tbp_pkg::TBP_CS_ELH];
              s_d.ch[x].edge_level_low = wr_byte[tbp_pkg::TBP_CS_ELL];
              s_d.ch[x].toggle_on_overflow = wr_byte[tbp_pkg::TBP_CS_TOV];
              s_d.ch[x].max_duty_select = wr_byte[tbp_pkg::TBP_CS_MAX];
            end
          end
        end
        tbp_pkg::TBP_C0CMP_ADDR, tbp_pkg::TBP_C1CMP_ADDR: begin
          for (int x = 0; x < 2; x++) begin
            if (s_q.awaddr == (x == 0 ?
                tbp_pkg::TBP_C0CMP_ADDR : tbp_pkg::TBP_C1CMP_ADDR)) begin
              wr_half = s_q.ch[x].cmp;
              if (s_q.wstrb[0]) wr_half[7:0] = s_q.wdata[7:0];
              if (s_q.wstrb[1]) wr_half[15:8] = s_q.wdata[15:8];
              s_d.ch[x].cmp = wr_half;
              s_d.last_wr = (x == 1);
            end
          end
        end
        tbp_pkg::TBP_COUNT_ADDR, tbp_pkg::TBP_ACTIVE_ADDR: begin
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      s_d.bresp = wr_ok ? tbp_pkg::TBP_RESP_OKAY : tbp_pkg::TBP_RESP_SLVERR;
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // ------------------------------------------------------------
    // Bus read channel
    // ------------------------------------------------------------
    case (s_axi_araddr_i)
      tbp_pkg::TBP_TCS_ADDR: begin
        rd_val[tbp_pkg::TBP_TCS_OVF] = s_q.overflow_flag;
        rd_val[tbp_pkg::TBP_TCS_OIE] = s_q.ovf_ie;
        rd_val[tbp_pkg::TBP_TCS_HALT] = s_q.counter_halt;
      end
      tbp_pkg::TBP_PERIOD_ADDR: rd_val[15:0] = s_q.period;
      tbp_pkg::TBP_C0CS_ADDR, tbp_pkg::TBP_C1CS_ADDR: begin
        for (int x = 0; x < 2; x++) begin
          if (s_axi_araddr_i == (x == 0 ?
              tbp_pkg::TBP_C0CS_ADDR : tbp_pkg::TBP_C1CS_ADDR)) begin
            rd_val[tbp_pkg::TBP_CS_FLAG] = s_q.ch[x].flag;
            rd_val[tbp_pkg::TBP_CS_IE] = s_q.ch[x].ie;
            rd_val[tbp_pkg::TBP_CS_LINK] = s_q.ch[x].link;
            rd_val[tbp_pkg::TBP_CS_MODE] = s_q.ch[x].mode_select_low;
            rd_val[tbp_pkg::TBP_CS_ELH] = s_q.ch[x].edge_level_high;
            rd_val[tbp_pkg::TBP_CS_ELL] = s_q.ch[x].edge_level_low;
            rd_val[tbp_pkg::TBP_CS_TOV] = s_q.ch[x].toggle_on_overflow;
            rd_val[tbp_pkg::TBP_CS_MAX] = s_q.ch[x].max_duty_select;
          end
        end
      end
      tbp_pkg::TBP_C0CMP_ADDR: rd_val[15:0] = s_q.ch[0].cmp;
      tbp_pkg::TBP_C1CMP_ADDR: rd_val[15:0] = s_q.ch[1].cmp;
      tbp_pkg::TBP_COUNT_ADDR: rd_val[15:0] = s_q.cnt;
      tbp_pkg::TBP_ACTIVE_ADDR: rd_val[0] = s_q.active;
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_arvalid_i && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_ok ? tbp_pkg::TBP_RESP_OKAY : tbp_pkg::TBP_RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // ------------------------------------------------------------
    // Counter, overflow and pair selection
    // ------------------------------------------------------------
    if (wrap) begin
      s_d.cnt = 16'h0000;
      s_d.overflow_flag = 1'b1;
    end else if (run) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    if (!linked) begin
      // Unlinked: the next link starts on channel 0
      s_d.active = 1'b0;
      s_d.last_wr = 1'b0;
    end else if (wrap) begin
      s_d.active = s_d.last_wr;
    end

    // ------------------------------------------------------------
    // Compare and pin action, per channel
    // ------------------------------------------------------------
    for (int x = 0; x < 2; x++) begin
      // Match on the edge the count arrives at the value, as the overflow
      // toggle does, so a pulse lasts exactly the compare value in clocks
      match[x] = run && en[x] && (s_d.cnt == cmp_val[x]);
      p = s_q.pin[x];
      if (wrap && s_q.ch[x].toggle_on_overflow) begin
        p = !p;
      end
      if (match[x]) begin
        s_d.ch[x].flag = 1'b1;
        case ({s_q.ch[x].edge_level_high, s_q.ch[x].edge_level_low})
          tbp_pkg::TBP_EDGE_TOGGLE: p = !p;
          tbp_pkg::TBP_EDGE_CLEAR: p = 1'b0;
          tbp_pkg::TBP_EDGE_SET: p = 1'b1;
          default: p = p;
        endcase
      end
      if (s_q.ch[x].max_duty_select && s_q.ch[x].toggle_on_overflow) begin
        p = 1'b1;
      end
      // A disabled channel parks low, so enabling starts from a known level
      s_d.pin[x] = en[x] ? p : 1'b0;
      s_d.oe[x] = en[x];
      s_d.ch_irq[x] = s_d.ch[x].flag && s_d.ch[x].ie;
    end
    s_d.ovf_irq = s_d.overflow_flag && s_d.ovf_ie;

    // Counter reset bit: restarts from zero, never stored, reads 0
    if (wr_ok && s_q.awaddr == tbp_pkg::TBP_TCS_ADDR && s_q.wstrb[0]
        && wr_byte[tbp_pkg::TBP_TCS_CRST]) begin
      s_d.cnt = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.counter_halt <= 1'b1;
      s_q.period <= tbp_pkg::TBP_PERIOD_RST;
      s_q.ch[0].cmp <= tbp_pkg::TBP_CMP_RST;
      s_q.ch[1].cmp <= tbp_pkg::TBP_CMP_RST;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o = s_q.wready;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign chan0_pin_o = s_q.pin[0];
  assign chan0_pin_oe_o = s_q.oe[0];
  assign chan1_pin_o = s_q.pin[1];
  assign chan1_pin_oe_o = s_q.oe[1];
  assign ovf_irq_o = s_q.ovf_irq;
  assign chan0_irq_o = s_q.ch_irq[0];
  assign chan1_irq_o = s_q.ch_irq[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_chan1_release: assert property (
    ce_i && s_q.ch[0].link |=> !chan1_pin_oe_o && chan0_pin_oe_o)
    else $error("chan1 pin still driven while linked");

  chk_ovf_flag_set: assert property (
    ce_i && !s_q.counter_halt && s_q.cnt == s_q.period
    |=> s_q.overflow_flag && s_q.cnt == 16'h0000)
    else $error("overflow did not set flag and wrap");

  chk_halt_freeze: assert property (
    s_q.counter_halt && !(s_q.aw_have && s_q.w_have)
    |=> $stable(s_q.cnt))
    else $error("counter moved while halted");

  chk_pair_swap: assert property (
    ce_i && s_q.ch[0].link && !s_q.counter_halt
    && s_q.cnt == s_q.period && !(s_q.aw_have && s_q.w_have)
    |=> s_q.active == $past(s_q.last_wr))
    else $error("active pair not taken from last write");

  chk_match_clear: assert property (
    ce_i && match[0] && s_q.ch[0].edge_level_high
    && !s_q.ch[0].edge_level_low && !s_q.ch[0].max_duty_select
    |=> !chan0_pin_o)
    else $error("clear on compare did not drive low");

  chk_max_duty: assert property (
    ce_i && en[0] && s_q.ch[0].max_duty_select
    && s_q.ch[0].toggle_on_overflow |=> chan0_pin_o)
    else $error("max duty output not high");

  chk_ovf_toggle: assert property (
    ce_i && en[1] && wrap && s_q.ch[1].toggle_on_overflow
    && !match[1] && !s_q.ch[1].max_duty_select
    |=> chan1_pin_o != $past(chan1_pin_o))
    else $error("pin not inverted at overflow");

  chk_no_ovf_toggle: assert property (
    ce_i && en[0] && !s_q.ch[0].toggle_on_overflow && !match[0]
    |=> $stable(chan0_pin_o))
    else $error("pin moved without toggle or compare");

  chk_read_answer: assert property (
    ce_i && s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered next cycle");

endmodule : tbp_timer

// ===== testbench/tbp_pin_meter.sv
// Pin observer that measures the high and low times of a channel pin
`timescale 1ns/1ps

module tbp_pin_meter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output int hi_len_o,
  output int lo_len_o
);
  int run_q;
  logic prev_q;

  // ----------------------------------------------------------------
  // Level run counter
  // ----------------------------------------------------------------
  // A length lands one edge after the change is seen, so readers wait two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 0;
      prev_q <= 1'b0;
      hi_len_o <= 0;
      lo_len_o <= 0;
    end else begin
      prev_q <= pin_i;
      if (pin_i != prev_q) begin
        run_q <= 1;
        if (prev_q) begin
          hi_len_o <= run_q;
        end else begin
          lo_len_o <= run_q;
        end
      end else begin
        run_q <= run_q + 1;
      end
    end
  end
endmodule : tbp_pin_meter

// ===== testbench/tbp_timer_tb.sv
// Self-checking bench for the buffered compare / PWM timer
`timescale 1ns/1ps

module tbp_timer_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp, wrsp;
  logic [31:0] rdata, rd_val;
  logic pin0, oe0, pin1, oe1, ovf_irq, c0_irq, c1_irq;
  int hi_len, lo_len;
  int hi_len1, lo_len1;
  int err_count = 0;
  int num_checks = 0;

  always #20 sys_clk = ~sys_clk;

  tbp_timer tbp_timer_i (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(1'b1),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .chan0_pin_o(pin0),
    .chan0_pin_oe_o(oe0), .chan1_pin_o(pin1), .chan1_pin_oe_o(oe1),
    .ovf_irq_o(ovf_irq), .chan0_irq_o(c0_irq), .chan1_irq_o(c1_irq));

  tbp_pin_meter tbp_pin_meter_i (.clk_i(sys_clk), .rst_i(rst),
    .pin_i(pin0), .hi_len_o(hi_len), .lo_len_o(lo_len));

  tbp_pin_meter tbp_pin_meter_ch1_i (.clk_i(sys_clk), .rst_i(rst),
    .pin_i(pin1), .hi_len_o(hi_len1), .lo_len_o(lo_len1));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic stall();
    check(32'h0, 32'h1);
    close_out();
  endtask : stall

  // ----------------------------------------------------------------
  // Bus and pin helpers
  // ----------------------------------------------------------------
  // A spare edge after each transfer keeps the next call from
  // assigning the same strobe twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    wrsp = bresp;
    bready <= 1'b0;
    if (n >= 100) stall();
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rd_val = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 100) stall();
    @(posedge sys_clk);
  endtask : rd

  task automatic wait_pin(input logic lvl, input logic ch = 1'b0);
    int n;
    n = 0;
    while ((ch ? pin1 : pin0) !== lvl && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) stall();
  endtask : wait_pin

  // Pulse between a rise and the following fall
  task automatic high_pulse(input int exp, input logic ch = 1'b0);
    wait_pin(1'b1, ch);
    wait_pin(1'b0, ch);
    repeat (2) @(posedge sys_clk);
    check(ch ? hi_len1 : hi_len, exp);
  endtask : high_pulse

  task automatic hold_check(input logic lvl);
    int k;
    k = 0;
    repeat (300) @(posedge sys_clk);
    repeat (300) begin
      @(posedge sys_clk);
      if (pin0 !== lvl) k++;
    end
    check(k, 0);
  endtask : hold_check

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(tbp_pkg::TBP_TCS_ADDR);
    check(rd_val, 32'h20);
    rd(tbp_pkg::TBP_PERIOD_ADDR);
    check(rd_val, 32'hffff);
    check({pin0, pin1, oe0, oe1, ovf_irq, c0_irq, c1_irq}, 32'h0);
    rd(8'h40);
    check(rd_val, 32'h0);
    check(rsp, tbp_pkg::TBP_RESP_SLVERR);
    wr(8'h44, 32'h1);
    check(wrsp, tbp_pkg::TBP_RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pwm();
    wr(tbp_pkg::TBP_TCS_ADDR, 32'h30);
    rd(tbp_pkg::TBP_COUNT_ADDR);
    check(rd_val, 32'h0);
    wr(tbp_pkg::TBP_PERIOD_ADDR, 32'hff);
    wr(tbp_pkg::TBP_C0CMP_ADDR, 32'h80);
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h5a);
    wr(tbp_pkg::TBP_TCS_ADDR, 32'h40);
    high_pulse(128);
    wait_pin(1'b1);
    repeat (2) @(posedge sys_clk);
    check(hi_len + lo_len, 256);
    check(oe0, 1'b1);
    wr(tbp_pkg::TBP_TCS_ADDR, 32'h40);
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h5a);
    check({ovf_irq, c0_irq}, 2'h0);
    wait_pin(1'b0);
    check({ovf_irq, c0_irq}, 2'h1);
    wait_pin(1'b1);
    check(ovf_irq, 1'b1);
    rd(tbp_pkg::TBP_TCS_ADDR);
    check(rd_val[7], 1'b1);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_modes();
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h1e);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    repeat (2) @(posedge sys_clk);
    check(lo_len, 128);
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h18);
    hold_check(1'b0);
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h1b);
    hold_check(1'b1);
    wr(tbp_pkg::TBP_TCS_ADDR, 32'h20);
    rd(tbp_pkg::TBP_COUNT_ADDR);
    wdata <= rd_val;
    repeat (10) @(posedge sys_clk);
    rd(tbp_pkg::TBP_COUNT_ADDR);
    check(rd_val, wdata);
    wr(tbp_pkg::TBP_TCS_ADDR, 32'h30);
    rd(tbp_pkg::TBP_COUNT_ADDR);
    check(rd_val, 32'h0);
    wr(tbp_pkg::TBP_TCS_ADDR, 32'h0);
    $display("test modes done");
  endtask : t_modes

  task automatic t_link();
    wr(tbp_pkg::TBP_C0CMP_ADDR, 32'h40);
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h3a);
    wr(tbp_pkg::TBP_C1CS_ADDR, 32'h1f);
    repeat (300) @(posedge sys_clk);
    check({oe0, oe1}, 2'h2);
    high_pulse(64);
    wait_pin(1'b1);
    wr(tbp_pkg::TBP_C1CMP_ADDR, 32'h20);
    wait_pin(1'b0);
    repeat (2) @(posedge sys_clk);
    check(hi_len, 64);
    high_pulse(32);
    rd(tbp_pkg::TBP_ACTIVE_ADDR);
    check(rd_val[0], 1'b1);
    wait_pin(1'b1);
    wr(tbp_pkg::TBP_C1CMP_ADDR, 32'h30);
    wait_pin(1'b0);
    repeat (2) @(posedge sys_clk);
    check(hi_len, 48);
    wait_pin(1'b1);
    wr(tbp_pkg::TBP_C0CMP_ADDR, 32'h60);
    wait_pin(1'b0);
    repeat (2) @(posedge sys_clk);
    check(hi_len, 48);
    high_pulse(96);
    rd(tbp_pkg::TBP_C0CS_ADDR);
    check(rd_val[7], 1'b1);
    $display("test link done");
  endtask : t_link

  // Unlinked channel 1 runs its own PWM once the link bit drops
  task automatic t_chan1();
    wr(tbp_pkg::TBP_C0CS_ADDR, 32'h0);
    wr(tbp_pkg::TBP_C1CMP_ADDR, 32'h20);
    wr(tbp_pkg::TBP_C1CS_ADDR, 32'h5a);
    check({oe0, oe1}, 2'h1);
    check(c1_irq, 1'b0);
    wait_pin(1'b0, 1'b1);
    high_pulse(32, 1'b1);
    check(c1_irq, 1'b1);
    wait_pin(1'b1, 1'b1);
    repeat (2) @(posedge sys_clk);
    check(hi_len1 + lo_len1, 256);
    $display("test chan1 done");
  endtask : t_chan1

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_pwm();
    t_modes();
    t_link();
    t_chan1();
    close_out();
  end
endmodule : tbp_timer_tb
